// >>> dag_pkg.sv
// package for the dual data address generator
// assumes a single core clock and synchronous reset
package dag_pkg;
  localparam int ADDR_W = 14;
  localparam int NUM_PTR = 4;
  localparam int NUM_GEN = 2;
  localparam logic [13:0] PTR_RESET = 14'h0000;
  localparam logic [13:0] STEP_RESET = 14'h0000;
  localparam logic [13:0] LEN_RESET = 14'h0000;
  localparam logic [13:0] BASE_RESET = 14'h0000;

  // register file targets for a load
  typedef enum logic [1:0] {
    SEL_PTR,
    SEL_STEP,
    SEL_LEN,
    SEL_BASE
  } reg_sel_t;

  // one indirect access request from the sequencer
  typedef struct packed {
    logic valid;
    logic [1:0] ptr;
    logic [1:0] step;
  } access_t;

  // one register load
  typedef struct packed {
    logic valid;
    logic gen;
    reg_sel_t sel;
    logic [1:0] idx;
    logic [13:0] data;
  } load_t;

  typedef struct packed {
    logic [13:0] ptr;
    logic [13:0] step;
    logic [13:0] len;
    logic [13:0] base;
  } slot_t;
endpackage : dag_pkg

// >>> dual_data_address_generator.sv
// two data address generators with post-modify and circular wrap
// assumes requests come from the sequencer synchronous to clk
module dual_data_address_generator (
  input wire logic clk,
  input wire logic rst,
  input dag_pkg::access_t genAReq,
  input dag_pkg::access_t genBReq,
  input wire logic genBToData,
  input wire logic bitReverse,
  input dag_pkg::access_t serialReq,
  input dag_pkg::load_t load,
  output logic [13:0] dataAddr,
  output logic dataAddrValid,
  output logic [13:0] programAddr,
  output logic programAddrValid,
  output logic [13:0] serialAddr,
  output logic serialAddrValid
);
  import dag_pkg::*;

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  typedef struct packed {
    slot_t [NUM_GEN-1:0][NUM_PTR-1:0] slots;
    logic [13:0] dataAddr;
    logic dataValid;
    logic [13:0] progAddr;
    logic progValid;
    logic [13:0] serAddr;
    logic serValid;
  } state_t;

  state_t st;
  state_t next_st;

  function automatic logic [13:0] postModify(input slot_t s,
                                             input logic [13:0] m);
    logic [13:0] sum;
    logic [13:0] top;
    sum = s.ptr + m;
    top = s.base + s.len;
    postModify = sum;
    if (s.len != 14'h0000) begin
      if (!m[13] && sum >= top) begin
        postModify = sum - s.len;
      end else if (m[13] && sum < s.base) begin
        postModify = sum + s.len;
      end
    end
  endfunction : postModify

  function automatic logic [13:0] reverse(input logic [13:0] a);
    for (int i = 0; i < ADDR_W; i++) begin
      reverse[i] = a[ADDR_W-1-i];
    end
  endfunction : reverse

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  always_comb begin
    slot_t sa;
    slot_t sb;
    slot_t ss;
    sa = st.slots[0][genAReq.ptr];
    sb = st.slots[1][genBReq.ptr];
    ss = st.slots[0][serialReq.ptr];
    next_st = st;
    next_st.dataValid = 1'b0;
    next_st.progValid = 1'b0;
    next_st.serValid = 1'b0;
    if (load.valid) begin
      case (load.sel)
        SEL_PTR: next_st.slots[load.gen][load.idx].ptr = load.data;
        SEL_STEP: next_st.slots[load.gen][load.idx].step = load.data;
        SEL_LEN: next_st.slots[load.gen][load.idx].len = load.data;
        SEL_BASE: next_st.slots[load.gen][load.idx].base = load.data;
        default: next_st.slots[load.gen][load.idx].ptr = load.data;
      endcase
    end
    // serial port borrows generator a when the core leaves it idle
    if (serialReq.valid && !genAReq.valid) begin
      next_st.serAddr = ss.ptr;
      next_st.serValid = 1'b1;
      next_st.slots[0][serialReq.ptr].ptr =
        postModify(ss, st.slots[0][serialReq.step].step);
    end
    if (genAReq.valid) begin
      next_st.dataAddr = bitReverse ? reverse(sa.ptr) : sa.ptr;
      next_st.dataValid = 1'b1;
      next_st.slots[0][genAReq.ptr].ptr =
        postModify(sa, st.slots[0][genAReq.step].step);
    end
    if (genBReq.valid) begin
      if (genBToData && !genAReq.valid) begin
        next_st.dataAddr = sb.ptr;
        next_st.dataValid = 1'b1;
      end else if (!genBToData) begin
        next_st.progAddr = sb.ptr;
        next_st.progValid = 1'b1;
      end
      if (!genBToData || !genAReq.valid) begin
        next_st.slots[1][genBReq.ptr].ptr =
          postModify(sb, st.slots[1][genBReq.step].step);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int g = 0; g < NUM_GEN; g++) begin
        for (int p = 0; p < NUM_PTR; p++) begin
          st.slots[g][p] <= '{PTR_RESET, STEP_RESET, LEN_RESET, BASE_RESET};
        end
      end
      st.dataAddr <= 14'h0000;
      st.dataValid <= 1'b0;
      st.progAddr <= 14'h0000;
      st.progValid <= 1'b0;
      st.serAddr <= 14'h0000;
      st.serValid <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign dataAddr = st.dataAddr;
  assign dataAddrValid = st.dataValid;
  assign programAddr = st.progAddr;
  assign programAddrValid = st.progValid;
  assign serialAddr = st.serAddr;
  assign serialAddrValid = st.serValid;

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  property p_dual;
    @(posedge clk) disable iff (rst)
    (genAReq.valid && genBReq.valid && !genBToData && !load.valid)
      |=> (dataAddrValid && programAddrValid);
  endproperty
  a_dual: assert property (p_dual)
    else $error("dual fetch missing");

  property p_addr;
    @(posedge clk) disable iff (rst)
    (genAReq.valid && !bitReverse)
      |=> dataAddr == $past(st.slots[0][genAReq.ptr].ptr);
  endproperty
  a_addr: assert property (p_addr)
    else $error("wrong data address");

  property p_rev;
    @(posedge clk) disable iff (rst)
    (genAReq.valid && bitReverse)
      |=> dataAddr == reverse($past(st.slots[0][genAReq.ptr].ptr));
  endproperty
  a_rev: assert property (p_rev)
    else $error("bit reverse wrong");

  property p_nowrap;
    @(posedge clk) disable iff (rst)
    (genBReq.valid && !genBToData && !load.valid
      && st.slots[1][genBReq.ptr].len == 14'h0000)
      |=> st.slots[1][$past(genBReq.ptr)].ptr ==
          $past(st.slots[1][genBReq.ptr].ptr
                + st.slots[1][genBReq.step].step);
  endproperty
  a_nowrap: assert property (p_nowrap)
    else $error("zero length wrapped");

  property p_refuse;
    @(posedge clk) disable iff (rst)
    (genBReq.valid && genBToData && genAReq.valid && !load.valid)
      |=> st.slots[1][$past(genBReq.ptr)].ptr
          == $past(st.slots[1][genBReq.ptr].ptr);
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("refused request moved its pointer");

  property p_serial;
    @(posedge clk) disable iff (rst)
    (serialReq.valid && !genAReq.valid)
      |=> serialAddrValid
          && serialAddr == $past(st.slots[0][serialReq.ptr].ptr);
  endproperty
  a_serial: assert property (p_serial)
    else $error("serial address wrong");

  property p_serdrop;
    @(posedge clk) disable iff (rst)
    (serialReq.valid && genAReq.valid) |=> !serialAddrValid;
  endproperty
  a_serdrop: assert property (p_serdrop)
    else $error("serial served while generator a busy");

  slot_t wrapSlot;
  logic [13:0] wrapStep;
  logic wrapInRange;

  // only forward steps shorter than the buffer are covered: a longer step is
  // folded back by a single length and may still land outside
  assign wrapSlot = st.slots[0][genAReq.ptr];
  assign wrapStep = st.slots[0][genAReq.step].step;
  assign wrapInRange = wrapSlot.len != 14'h0000
    && wrapSlot.ptr >= wrapSlot.base
    && wrapSlot.ptr - wrapSlot.base < wrapSlot.len
    && !wrapStep[13] && wrapStep < wrapSlot.len;

  property p_wrap;
    @(posedge clk) disable iff (rst)
    (genAReq.valid && !load.valid && wrapInRange)
      |=> st.slots[0][$past(genAReq.ptr)].ptr >= $past(wrapSlot.base)
          && st.slots[0][$past(genAReq.ptr)].ptr - $past(wrapSlot.base)
             < $past(wrapSlot.len);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("pointer left its buffer");
endmodule : dual_data_address_generator

// >>> seq_model.sv
// sequencer stand-in: drives register loads and access requests
// assumes each task is entered just after a rising edge of clk
module seq_model (
  input wire logic clk,
  output dag_pkg::access_t genAReq,
  output dag_pkg::access_t genBReq,
  output dag_pkg::access_t serialReq,
  output logic genBToData,
  output logic bitReverse,
  output dag_pkg::load_t load
);
  timeunit 1ns;
  timeprecision 1ns;
  import dag_pkg::*;
  initial begin
    genAReq = '0;
    genBReq = '0;
    serialReq = '0;
    genBToData = 1'b0;
    bitReverse = 1'b0;
    load = '0;
  end
  // a load holds one edge, then idles one so calls never collide;
  // standing requests are dropped so a load never rides on an access
  task automatic ld(input logic g, input reg_sel_t s, input logic [1:0] i,
    input logic [13:0] d);
    genAReq <= '0;
    genBReq <= '0;
    serialReq <= '0;
    load <= '{1'b1, g, s, i, d};
    @(posedge clk) #1;
    load <= '0;
    @(posedge clk) #1;
  endtask : ld
  // requests stay up, so consecutive calls are back to back
  task automatic go(input access_t a, input access_t b, input access_t s,
    input logic toData, input logic rev);
    genAReq <= a;
    genBReq <= b;
    serialReq <= s;
    genBToData <= toData;
    bitReverse <= rev;
    @(posedge clk) #1;
  endtask : go
endmodule : seq_model

// >>> dual_data_address_generator_bench.sv
// self-checking bench for the dual data address generator
// assumes seq_model issues every load and request
module dual_data_address_generator_bench import dag_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, toD, rev, dV, pV, sV;
  access_t aR, bR, sR;
  load_t ldv;
  logic [13:0] dA, pA, sA;
  int miscompares = 0;
  int numChecks = 0;
  localparam access_t N = '0;
  seq_model seq_model_inst (.clk(clk), .genAReq(aR), .genBReq(bR),
    .serialReq(sR), .genBToData(toD), .bitReverse(rev), .load(ldv));
  dual_data_address_generator dual_data_address_generator_inst (
    .clk(clk), .rst(rst), .genAReq(aR), .genBReq(bR), .genBToData(toD),
    .bitReverse(rev), .serialReq(sR), .load(ldv), .dataAddr(dA),
    .dataAddrValid(dV), .programAddr(pA), .programAddrValid(pV),
    .serialAddr(sA), .serialAddrValid(sV));
  function automatic access_t acc(input int p, input int s);
    return '{1'b1, p[1:0], s[1:0]};
  endfunction : acc
  task automatic chk(input logic [13:0] got, input logic [13:0] exp,
    input logic v);
    numChecks++;
    if (v !== 1'b1 || got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h want %h valid %b", $time, got, exp, v);
    end
  endtask : chk
  task automatic linearStep();
    seq_model_inst.ld(1'b0, SEL_PTR, 2'd0, 14'h000a);
    seq_model_inst.ld(1'b0, SEL_STEP, 2'd1, 14'h0003);
    seq_model_inst.go(acc(0, 1), N, N, 1'b0, 1'b0);
    chk(dA, 14'h000a, dV);
    seq_model_inst.go(acc(0, 1), N, N, 1'b0, 1'b0);
    chk(dA, 14'h000d, dV);
  endtask : linearStep
  task automatic circularWrap();
    logic [13:0] e[4] = '{14'h0020, 14'h0022, 14'h0021, 14'h0020};
    seq_model_inst.ld(1'b0, SEL_BASE, 2'd1, 14'h0020);
    seq_model_inst.ld(1'b0, SEL_PTR, 2'd1, 14'h0020);
    seq_model_inst.ld(1'b0, SEL_LEN, 2'd1, 14'h0003);
    seq_model_inst.ld(1'b0, SEL_STEP, 2'd2, 14'h0002);
    for (int i = 0; i < 4; i++) begin
      seq_model_inst.go(acc(1, 2), N, N, 1'b0, 1'b0);
      chk(dA, e[i], dV);
    end
  endtask : circularWrap
  task automatic dualFetch();
    seq_model_inst.ld(1'b1, SEL_PTR, 2'd0, 14'h0100);
    seq_model_inst.ld(1'b1, SEL_STEP, 2'd0, 14'h0001);
    seq_model_inst.go(acc(0, 1), acc(0, 0), N, 1'b0, 1'b0);
    chk(dA, 14'h0010, dV);
    chk(pA, 14'h0100, pV);
    seq_model_inst.go(N, acc(0, 0), N, 1'b1, 1'b0);
    chk(dA, 14'h0101, dV);
    seq_model_inst.go(acc(0, 1), N, N, 1'b0, 1'b1);
    chk(dA, 14'h3200, dV);
    seq_model_inst.go(acc(0, 1), acc(0, 0), N, 1'b1, 1'b0);
    chk(dA, 14'h0016, dV);
    seq_model_inst.go(N, acc(0, 0), N, 1'b1, 1'b0);
    chk(dA, 14'h0102, dV);
  endtask : dualFetch
  task automatic serialWrap();
    seq_model_inst.go(acc(0, 1), N, acc(1, 2), 1'b0, 1'b0);
    chk(dA, 14'h0019, dV);
    numChecks++;
    if (sV !== 1'b0) begin
      miscompares++;
      $display("ERROR %0t serial served while generator a busy", $time);
    end
    seq_model_inst.go(N, N, acc(1, 2), 1'b0, 1'b0);
    chk(sA, 14'h0022, sV);
    seq_model_inst.go(N, N, acc(1, 2), 1'b0, 1'b0);
    chk(sA, 14'h0021, sV);
    seq_model_inst.go(N, N, N, 1'b0, 1'b0);
  endtask : serialWrap
  task automatic printVerdict();
    $display("checks %0d mismatches %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : printVerdict
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    linearStep();
    circularWrap();
    dualFetch();
    serialWrap();
    printVerdict();
  end
endmodule : dual_data_address_generator_bench
